// ### pkg/adcsq_pkg.sv
// constants and types shared by the conversion sequencer
package adcsq_pkg;
  localparam int unsigned SAMPLE_PERIODS   = 4;
  localparam int unsigned CONVERT_PERIODS  = 12;
  localparam int unsigned TOTAL_PERIODS    = SAMPLE_PERIODS + CONVERT_PERIODS;
  localparam int unsigned RESULT_W         = 12;
  localparam int unsigned DIV_SEL_W        = 3;
  localparam int unsigned PRESCALE_W       = 7;
  localparam int unsigned SRC_SEL_W        = 4;
  localparam int unsigned CHAN_SEL_W       = 4;
  localparam int unsigned REF_SEL_W        = 2;
  localparam logic [11:0] RESULT_FULL_SCALE = 12'hfff;
  localparam logic [3:0]  SRC_EXTERNAL      = 4'h0;
  localparam logic [3:0]  CHAN_NONE         = 4'hf;
  localparam logic [2:0]  DIV_BY_1          = 3'h0;
  localparam logic [4:0]  PERIOD_CNT_LAST   = 5'h0f;
  localparam logic [4:0]  SAMPLE_CNT_LAST   = 5'h03;
  localparam logic [4:0]  PERIOD_CNT_ZERO   = 5'h00;
  localparam logic [6:0]  PRESCALE_ZERO     = 7'h00;
  localparam logic [7:0]  RESULT_BYTE_ZERO  = 8'h00;

  typedef enum logic [1:0] {
    ADCSQ_IDLE    = 2'b00,
    ADCSQ_ARMED   = 2'b01,
    ADCSQ_SAMPLE  = 2'b10,
    ADCSQ_CONVERT = 2'b11
  } adcsq_state_e;
endpackage

// ### verilog/adcsq_clkdiv.sv
// converter clock enable derived from the system clock by a power-of-two divider
module adcsq_clkdiv
  import adcsq_pkg::*;
(
  input  wire logic                 clk,      // system clock
  input  wire logic                 rstn,     // async reset, active low
  input  wire logic                 ce,       // global clock enable
  input  wire logic                 run,      // divider counts while high
  input  wire logic [DIV_SEL_W-1:0] div_sel,  // divider select
  output logic                      tick      // one-cycle converter clock period end
);
  logic [PRESCALE_W-1:0] cnt_r;
  logic [PRESCALE_W-1:0] limit;

  // divide by 2**sel: period ends when the counter reaches 2**sel - 1
  assign limit = PRESCALE_W'((8'h01 << div_sel) - 8'h01);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      cnt_r <= PRESCALE_ZERO;
    else if (ce)
    begin
      if (!run || cnt_r == limit)
        cnt_r <= PRESCALE_ZERO;
      else
        cnt_r <= cnt_r + PRESCALE_W'(1);
    end
  end

  assign tick = ce && run && (cnt_r == limit);
endmodule

// ### verilog/adcsq_top.sv
// conversion sequencer: start detection, timing, busy/flag, result formatting
// What this block does
// - converter clock comes from the system clock through the divider select field.
// - divider encodings 000..111 give divide by 1,2,4,...,128.
// - converter is powered only while power enable is one.
// - source select picks external pin channel or internal signal; channel select picks pin.
// - internal source disconnects the external channel regardless of channel select.
// - reference select chooses the reference; amplifier settings apply when amplifier chosen.
// - format bit arranges the 12-bit result across high and low registers.
// - interrupt goes out only when global and converter enables are both high.
// - a low-high-low pulse on the start bit begins a conversion.
// - busy stays high through the whole conversion.
// - at completion busy drops and the new result is readable.
// - completion also sets the interrupt request flag.
// - a conversion takes 4 sampling plus 12 converting periods, 16 total.
// - power enable low means converter circuits draw no power.
// - result is an unsigned 12-bit code, full scale at the reference.
// - one code step is the reference divided by 4096.
// - transitions sit half a step low; full scale one and a half steps low.
module adcsq_top
  import adcsq_pkg::*;
(
  input  wire logic                  clk,                       // 100 MHz system clock
  input  wire logic                  rstn,                      // async reset, active low
  input  wire logic                  ce,                        // clock enable, freezes state
  input  wire logic                  start_bit,                 // software start bit level
  input  wire logic                  converter_power_enable,    // power enable bit
  input  wire logic [DIV_SEL_W-1:0]  conv_clock_divider_select, // divider select field
  input  wire logic [SRC_SEL_W-1:0]  input_source_select,       // source select field
  input  wire logic [CHAN_SEL_W-1:0] external_channel_select,   // pin channel select field
  input  wire logic [REF_SEL_W-1:0]  reference_source_select,   // reference select field
  input  wire logic                  result_format_select,      // 0: left, 1: right justified
  input  wire logic                  global_interrupt_enable,   // master interrupt enable
  input  wire logic                  converter_interrupt_enable,// converter interrupt enable
  input  wire logic                  irq_flag_clear,            // software clears request flag
  input  wire logic [RESULT_W-1:0]   analog_code,               // quantised code from the array
  output logic                       conversion_busy_flag,      // conversion in progress
  output logic                       irq_request_flag,          // sticky completion request
  output logic                       irq_out,                   // gated interrupt to the core
  output logic [7:0]                 result_high_reg,           // result high byte
  output logic [7:0]                 result_low_reg,            // result low byte
  output logic                       analog_power_on,           // analog bias enable
  output logic                       sample_hold,               // sampling switch closed
  output logic                       ext_channel_connect,       // external pin path closed
  output logic [CHAN_SEL_W-1:0]      ext_channel_active,        // pin channel routed
  output logic [SRC_SEL_W-1:0]       internal_source_active,    // internal source routed
  output logic [REF_SEL_W-1:0]       reference_active,          // reference routed
  output logic                       amplifier_ref_active       // amplifier output is reference
);
  adcsq_state_e state_r;
  adcsq_state_e state_nxt;
  logic [4:0]   period_r;
  logic         start_prev_r;
  logic         start_rise;
  logic         start_fall;
  logic         tick;
  logic         running;
  logic         done;
  localparam logic [1:0] REF_AMPLIFIER = 2'h3;

  // start bit is written by logic on the same clock: no synchroniser needed
  assign start_rise = start_bit && !start_prev_r;
  assign start_fall = !start_bit && start_prev_r;
  assign running    = (state_r == ADCSQ_SAMPLE) || (state_r == ADCSQ_CONVERT);
  assign done       = (state_r == ADCSQ_CONVERT) && tick && (period_r == PERIOD_CNT_LAST);

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      start_prev_r <= 1'b0;
    else if (ce)
      start_prev_r <= start_bit;
  end

  // divider is held clear outside a conversion, so each launch starts a full period
  adcsq_clkdiv u_clkdiv (
    .clk     (clk),
    .rstn    (rstn),
    .ce      (ce),
    .run     (running),
    .div_sel (conv_clock_divider_select),
    .tick    (tick)
  );

  // rise arms, the following fall launches; a restart mid-conversion is honoured
  always_comb
  begin
    state_nxt = state_r;
    unique case (state_r)
      ADCSQ_IDLE:
        if (start_rise && converter_power_enable)
          state_nxt = ADCSQ_ARMED;
      ADCSQ_ARMED:
        if (!converter_power_enable)
          state_nxt = ADCSQ_IDLE;
        else if (start_fall)
          state_nxt = ADCSQ_SAMPLE;
      ADCSQ_SAMPLE:
        if (!converter_power_enable)
          state_nxt = ADCSQ_IDLE;
        else if (start_rise)
          state_nxt = ADCSQ_ARMED;
        else if (tick && period_r == SAMPLE_CNT_LAST)
          state_nxt = ADCSQ_CONVERT;
      ADCSQ_CONVERT:
        if (!converter_power_enable || done)
          state_nxt = ADCSQ_IDLE;
        else if (start_rise)
          state_nxt = ADCSQ_ARMED;
    endcase
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      state_r <= ADCSQ_IDLE;
    else if (ce)
      state_r <= state_nxt;
  end

  // period counter across the 16 converter clocks
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      period_r <= PERIOD_CNT_ZERO;
    else if (ce)
    begin
      if (!running || state_nxt == ADCSQ_ARMED || state_nxt == ADCSQ_IDLE)
        period_r <= PERIOD_CNT_ZERO;
      else if (tick)
        period_r <= period_r + 5'h01;
    end
  end

  // busy from launch until completion
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      conversion_busy_flag <= 1'b0;
    else if (ce)
      conversion_busy_flag <= (state_nxt == ADCSQ_SAMPLE)
                              || (state_nxt == ADCSQ_CONVERT);
  end

  // completion sets the request; set wins over a same-cycle clear
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_request_flag <= 1'b0;
    else if (ce)
    begin
      if (done)
        irq_request_flag <= 1'b1;
      else if (irq_flag_clear)
        irq_request_flag <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      irq_out <= 1'b0;
    else if (ce)
      irq_out <= (done || (irq_request_flag && !irq_flag_clear))
                 && global_interrupt_enable && converter_interrupt_enable;
  end

  // result latched only at completion and held otherwise; code scaling and
  // transition offsets live in the analog array, the code is taken as is
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      result_high_reg <= RESULT_BYTE_ZERO;
      result_low_reg  <= RESULT_BYTE_ZERO;
    end
    else if (ce && done)
    begin
      if (result_format_select)
      begin
        result_high_reg <= {4'h0, analog_code[11:8]};
        result_low_reg  <= analog_code[7:0];
      end
      else
      begin
        result_high_reg <= analog_code[11:4];
        result_low_reg  <= {analog_code[3:0], 4'h0};
      end
    end
  end

  // analog routing; everything except the reference routing off while unpowered
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
    begin
      analog_power_on        <= 1'b0;
      sample_hold            <= 1'b0;
      ext_channel_connect    <= 1'b0;
      ext_channel_active     <= CHAN_NONE;
      internal_source_active <= SRC_EXTERNAL;
      reference_active       <= 2'h0;
      amplifier_ref_active   <= 1'b0;
    end
    else if (ce)
    begin
      analog_power_on      <= converter_power_enable;
      sample_hold          <= converter_power_enable && state_nxt == ADCSQ_SAMPLE;
      ext_channel_connect  <= converter_power_enable
                              && input_source_select == SRC_EXTERNAL;
      ext_channel_active   <= (converter_power_enable && input_source_select == SRC_EXTERNAL)
                              ? external_channel_select : CHAN_NONE;
      internal_source_active <= converter_power_enable ? input_source_select : SRC_EXTERNAL;
      reference_active     <= reference_source_select;
      amplifier_ref_active <= converter_power_enable
                              && reference_source_select == REF_AMPLIFIER;
    end
  end

  // checks
  // slowest conversion: sixteen periods of the largest divider
  localparam logic [11:0] BUSY_LEN_MAX = 12'(TOTAL_PERIODS << PRESCALE_W);
  logic [11:0] busy_len_r;
  logic [9:0]  hold_len_r;
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      busy_len_r <= 12'h000;
    else if (ce)
      busy_len_r <= conversion_busy_flag ? busy_len_r + 12'h001 : 12'h000;
  end

  // sampling window length in system clocks, for the divider in use
  always_ff @(posedge clk or negedge rstn)
  begin
    if (!rstn)
      hold_len_r <= 10'h000;
    else if (ce)
      hold_len_r <= sample_hold ? hold_len_r + 10'h001 : 10'h000;
  end

  chk_busy_on_launch: assert property (@(posedge clk) disable iff (!rstn)
    ce && state_r == ADCSQ_ARMED && start_fall && converter_power_enable
    |=> conversion_busy_flag)
    else $error("busy not raised after start pulse");
  chk_done_flags: assert property (@(posedge clk) disable iff (!rstn)
    ce && done |=> !conversion_busy_flag && irq_request_flag)
    else $error("completion did not drop busy and set request");
  chk_irq_gate: assert property (@(posedge clk) disable iff (!rstn)
    irq_out |-> $past(global_interrupt_enable) && $past(converter_interrupt_enable))
    else $error("interrupt out without both enables");
  chk_result_hold: assert property (@(posedge clk) disable iff (!rstn)
    !$past(done) |-> $stable(result_high_reg) && $stable(result_low_reg))
    else $error("result changed without completion");
  chk_ext_cut: assert property (@(posedge clk) disable iff (!rstn)
    ext_channel_connect |-> $past(input_source_select) == SRC_EXTERNAL)
    else $error("external channel connected with internal source");
  chk_power_gate: assert property (@(posedge clk) disable iff (!rstn)
    !converter_power_enable && ce |=> !analog_power_on && !sample_hold)
    else $error("analog active while unpowered");
  chk_busy_length: assert property (@(posedge clk) disable iff (!rstn)
    busy_len_r <= BUSY_LEN_MAX)
    else $error("conversion longer than 16 slowest periods");
  chk_div_by_one: assert property (@(posedge clk) disable iff (!rstn)
    ce && running && conv_clock_divider_select == DIV_BY_1 |-> tick)
    else $error("divide by one must tick every cycle");
  chk_sample_len: assert property (@(posedge clk) disable iff (!rstn)
    ce && state_r == ADCSQ_SAMPLE && state_nxt == ADCSQ_CONVERT |-> period_r == SAMPLE_CNT_LAST)
    else $error("sampling not four periods");
  chk_sample_window: assert property (@(posedge clk) disable iff (!rstn)
    ce && state_r == ADCSQ_CONVERT && $past(state_r) == ADCSQ_SAMPLE
    |-> hold_len_r == 10'(SAMPLE_PERIODS << conv_clock_divider_select))
    else $error("sampling window not four converter periods");
  chk_irq_off: assert property (@(posedge clk) disable iff (!rstn)
    ce && !global_interrupt_enable |=> !irq_out)
    else $error("interrupt out with global enable low");
  chk_start_refused: assert property (@(posedge clk) disable iff (!rstn)
    ce && state_r == ADCSQ_IDLE && !converter_power_enable |=> state_r == ADCSQ_IDLE)
    else $error("start accepted while unpowered");
  chk_int_cut: assert property (@(posedge clk) disable iff (!rstn)
    ce && input_source_select != SRC_EXTERNAL |=> !ext_channel_connect
    && ext_channel_active == CHAN_NONE)
    else $error("pin path left open with internal source");
  chk_ext_route: assert property (@(posedge clk) disable iff (!rstn)
    ce && converter_power_enable && input_source_select == SRC_EXTERNAL
    |=> ext_channel_active == $past(external_channel_select))
    else $error("selected pin channel not routed");
  chk_fmt_right: assert property (@(posedge clk) disable iff (!rstn)
    ce && done && result_format_select
    |=> result_high_reg[7:4] == 4'h0 && result_low_reg == $past(analog_code[7:0]))
    else $error("right-justified result misplaced");
  chk_fmt_left: assert property (@(posedge clk) disable iff (!rstn)
    ce && done && !result_format_select
    |=> result_low_reg[3:0] == 4'h0 && result_high_reg == $past(analog_code[11:4]))
    else $error("left-justified result misplaced");
  chk_restart: assert property (@(posedge clk) disable iff (!rstn)
    ce && running && start_rise && converter_power_enable |=> !conversion_busy_flag)
    else $error("new start did not abort the running conversion");
  chk_flag_clear: assert property (@(posedge clk) disable iff (!rstn)
    ce && irq_flag_clear && !done |=> !irq_request_flag)
    else $error("request flag not cleared");

  cov_conversion: cover property (@(posedge clk) disable iff (!rstn) done);
  cov_irq: cover property (@(posedge clk) disable iff (!rstn) irq_out);
  cov_set_clear: cover property (@(posedge clk) disable iff (!rstn) done && irq_flag_clear);
  cov_internal: cover property (@(posedge clk) disable iff (!rstn)
    done && input_source_select != SRC_EXTERNAL);
  cov_restart: cover property (@(posedge clk) disable iff (!rstn) running && start_rise);
endmodule

// ### sim/adcsq_analog_model.sv
// partner model: analog channels and references feeding the quantised code
module adcsq_analog_model
  import adcsq_pkg::*;
(
  input  wire logic                  clk,          // system clock
  input  wire logic                  power_on,     // analog bias enable
  input  wire logic                  ext_connect,  // pin path closed
  input  wire logic [CHAN_SEL_W-1:0] ext_chan,     // routed pin channel
  input  wire logic [SRC_SEL_W-1:0]  int_src,      // routed internal source
  input  wire logic [REF_SEL_W-1:0]  ref_sel,      // routed reference
  output logic      [RESULT_W-1:0]   code          // quantised code
);
  timeunit 1ns;
  timeprecision 1ps;
  logic [RESULT_W-1:0] float_r;
  initial float_r = 12'h5a3;
  // floating input: changes every cycle so a stale code never looks valid
  always @(posedge clk)
    float_r <= {float_r[10:0], ~float_r[11]};
  always_comb
    if (!power_on)
      code = float_r;
    else if (int_src != SRC_EXTERNAL)
      code = {ref_sel, 2'h2, int_src, 4'h9};
    else if (ext_connect)
      code = {ref_sel, 6'h15, ext_chan};
    else
      code = float_r;
endmodule

// ### sim/tb.sv
// self-checking bench for the conversion sequencer
module tb
  import adcsq_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clk, rstn, ce, start_bit, pwr, fmt, gie, cie, clr;
  logic [2:0]  div;
  logic [3:0]  src, chan;
  logic [1:0]  rsel;
  logic [2:0]  sv;
  wire  [11:0] code;
  logic        busy, irqf, irq_out, apwr, sh_o, ext_con, amp_ref;
  logic [7:0]  res_hi, res_lo;
  logic [3:0]  ext_act, int_act;
  logic [1:0]  ref_act;
  int          miscompares, n_tests, n, sh;

  adcsq_top DUT (.clk(clk), .rstn(rstn), .ce(ce), .start_bit(start_bit),
    .converter_power_enable(pwr), .conv_clock_divider_select(div),
    .input_source_select(src), .external_channel_select(chan),
    .reference_source_select(rsel), .result_format_select(fmt),
    .global_interrupt_enable(gie), .converter_interrupt_enable(cie),
    .irq_flag_clear(clr), .analog_code(code), .conversion_busy_flag(busy),
    .irq_request_flag(irqf), .irq_out(irq_out), .result_high_reg(res_hi),
    .result_low_reg(res_lo), .analog_power_on(apwr), .sample_hold(sh_o),
    .ext_channel_connect(ext_con), .ext_channel_active(ext_act),
    .internal_source_active(int_act), .reference_active(ref_act),
    .amplifier_ref_active(amp_ref));

  adcsq_analog_model u_analog (.clk(clk), .power_on(apwr), .ext_connect(ext_con),
    .ext_chan(ext_act), .int_src(int_act), .ref_sel(ref_act), .code(code));

  initial
  begin
    clk = 1'b0;
    forever #5 clk = ~clk;
  end

  task automatic conclude();
    $display("comparisons %0d mismatches %0d", n_tests, miscompares);
    if (miscompares == 0 && n_tests > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    n_tests++;
    if (seen !== exp)
    begin
      miscompares++;
      $display("MISMATCH at %0t: got %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic tick();
    @(posedge clk);
    #1;
  endtask

  // rise arms, fall launches
  task automatic pulse_start();
    start_bit = 1'b1;
    tick();
    start_bit = 1'b0;
    tick();
  endtask

  task automatic run_conv();
    pulse_start();
    n = 0;
    // first sampling cycle is already showing when the start pulse ends
    sh = (sh_o === 1'b1) ? 1 : 0;
    repeat (3000)
    begin
      tick();
      n++;
      if (n == 1)
        chk({14'h0, busy, sh_o}, 16'h0003);
      if (sh_o === 1'b1)
        sh++;
      if (busy !== 1'b1)
        break;
    end
    if (busy === 1'b1)
    begin
      miscompares++;
      conclude();
    end
  endtask

  // result bytes as the format bit arranges them
  task automatic chk_res();
    logic [11:0] c;
    c = (src != 4'h0) ? {rsel, 2'h2, src, 4'h9} : {rsel, 6'h15, chan};
    chk({res_hi, res_lo}, fmt ? {4'h0, c} : {c, 4'h0});
  endtask

  initial
  begin
    miscompares = 0;
    n_tests = 0;
    {rstn, start_bit, pwr, fmt, gie, cie, clr} = '0;
    ce = 1'b1;
    div = 3'h0;
    src = 4'h0;
    chan = 4'h0;
    rsel = 2'h0;
    repeat (16) @(posedge clk);
    #1;
    rstn = 1'b1;
    chk({15'h0, busy}, 16'h0000);
    chk({12'h0, ext_act}, 16'h000f);
    pwr = 1'b1;
    tick();
    tick();
    chk({15'h0, apwr}, 16'h0001);
    for (int s = 0; s < 8; s++)
    begin
      sv = s[2:0];
      div = sv;
      fmt = sv[2];
      gie = sv[0];
      cie = sv[1];
      src = (s > 5) ? {1'b0, sv} : 4'h0;
      chan = {1'b0, sv} + 4'h7;
      rsel = sv[1:0];
      tick();
      tick();
      chk({15'h0, ext_con}, {15'h0, src == 4'h0});
      chk({12'h0, ext_act}, (src == 4'h0) ? {12'h0, chan} : 16'h000f);
      chk({12'h0, int_act}, {12'h0, src});
      chk({13'h0, amp_ref, ref_act}, {13'h0, rsel == 2'h3, rsel});
      run_conv();
      chk(16'(n), 16'(16 * (1 << s)));
      chk(16'(sh), 16'(4 * (1 << s)));
      chk_res();
      chk({14'h0, irqf, irq_out}, {14'h0, 1'b1, gie & cie});
      clr = 1'b1;
      tick();
      clr = 1'b0;
      tick();
      chk({14'h0, irqf, irq_out}, 16'h0000);
    end
    // power dropped mid-conversion: no result, no flag, old result kept
    div = 3'h1;
    pulse_start();
    repeat (5) tick();
    pwr = 1'b0;
    tick();
    tick();
    chk({14'h0, busy, irqf}, 16'h0000);
    chk_res();
    pulse_start();
    tick();
    tick();
    chk({15'h0, busy}, 16'h0000);
    // new start in mid-conversion restarts the full count
    pwr = 1'b1;
    src = 4'h0;
    chan = 4'h3;
    tick();
    tick();
    pulse_start();
    repeat (9) tick();
    run_conv();
    chk(16'(n), 16'(16 * 2));
    chk_res();
    // clock enable low freezes a running conversion
    clr = 1'b1;
    tick();
    clr = 1'b0;
    pulse_start();
    ce = 1'b0;
    repeat (40) tick();
    chk({14'h0, busy, irqf}, 16'h0002);
    ce = 1'b1;
    n = 0;
    while (busy === 1'b1 && n < 100)
    begin
      tick();
      n++;
    end
    chk(16'(n), 16'(16 * 2));
    chk({15'h0, irqf}, 16'h0001);
    conclude();
  end
endmodule
